// ### core/djk_stage.sv
`timescale 1ns/10ps
`default_nettype none
`include "djk_defines.svh"

module djk_stage
  import djk_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_ff_clk,
  input  wire logic i_set_req,
  input  wire logic i_reset_req,
  input  wire logic i_clear_n,
  output logic      o_q,
  output logic      o_q_n
);

  djk_state_type state_reg;
  djk_state_type state_next;
  logic          rise;
  logic          fall;

  assign rise = i_ff_clk && !state_reg.clk_prev;
  assign fall = !i_ff_clk && state_reg.clk_prev;

  always_comb
  begin
    state_next = state_reg;
    state_next.clk_prev = i_ff_clk;
    unique case (state_reg.phase)
      DJK_IDLE:
      begin
        // Slave kept apart; master loaded only on the pulse start [R1] [R2] [R3]
        if (rise)
        begin
          unique case ({i_set_req, i_reset_req}) // [R6]
            2'b00: state_next.master = state_reg.slave;
            2'b01: state_next.master = 1'b0;
            2'b10: state_next.master = 1'b1;
            2'b11: state_next.master = !state_reg.slave;
          endcase
          state_next.phase = DJK_SAMPLED;
        end
      end
      DJK_SAMPLED:
      begin
        // Inputs ignored now; transfer on pulse end [R4] [R5] [R7]
        if (fall)
        begin
          state_next.slave = state_reg.master;
          state_next.phase = DJK_IDLE;
        end
      end
      default:
        state_next.phase = DJK_IDLE;
    endcase
    // Clear wins over any pulse in flight [R8]
    if (!i_clear_n)
    begin
      state_next.master = `DJK_STATE_RST;
      state_next.slave  = `DJK_STATE_RST;
      state_next.phase  = DJK_IDLE;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_reg <= '{DJK_IDLE, 1'b0, `DJK_STATE_RST, `DJK_STATE_RST};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_q   = state_reg.slave;
  assign o_q_n = !state_reg.slave;

  sequence s_pulse_start;
    rise && i_clear_n && (state_reg.phase == DJK_IDLE);
  endsequence

  // Slave stays isolated, so a pulse start never moves the outputs
  a_out_hold_pulse: assert property (@(posedge i_mclk) disable iff (i_rst) // [R2] [R7]
    s_pulse_start |=> $stable(o_q))
    else $error("Output changed at pulse start");
  a_set_loads: assert property (@(posedge i_mclk) disable iff (i_rst) // [R3] [R6]
    s_pulse_start and (i_set_req && !i_reset_req) |=> state_reg.master)
    else $error("Set request not loaded");
  a_reset_loads: assert property (@(posedge i_mclk) disable iff (i_rst) // [R6]
    s_pulse_start and (!i_set_req && i_reset_req) |=> !state_reg.master)
    else $error("Reset request not loaded");
  a_hold_loads: assert property (@(posedge i_mclk) disable iff (i_rst) // [R6]
    s_pulse_start and (!i_set_req && !i_reset_req) |=> state_reg.master == $past(o_q))
    else $error("Hold not loaded");
  a_toggle_loads: assert property (@(posedge i_mclk) disable iff (i_rst) // [R6]
    s_pulse_start and (i_set_req && i_reset_req) |=> state_reg.master == !$past(o_q))
    else $error("Toggle not loaded");
  a_master_idle: assert property (@(posedge i_mclk) disable iff (i_rst) // [R1]
    (state_reg.phase == DJK_IDLE) && !rise && i_clear_n |=> $stable(state_reg.master))
    else $error("Master changed outside pulse");
  a_master_frozen: assert property (@(posedge i_mclk) disable iff (i_rst) // [R4]
    (state_reg.phase == DJK_SAMPLED) && !fall && i_clear_n |=> $stable(state_reg.master))
    else $error("Master changed while inputs disabled");
  a_transfer_end: assert property (@(posedge i_mclk) disable iff (i_rst) // [R5]
    (state_reg.phase == DJK_SAMPLED) && fall && i_clear_n |=> o_q == $past(state_reg.master))
    else $error("Master not transferred");
  a_clear_forces: assert property (@(posedge i_mclk) disable iff (i_rst) // [R8]
    !i_clear_n |=> !o_q && o_q_n)
    else $error("Clear did not force zero");

endmodule // djk_stage

`default_nettype wire

// ### core/djk_defines.svh
`ifndef DJK_DEFINES_SVH
`define DJK_DEFINES_SVH

`define DJK_NUM_FF      2
`define DJK_STATE_RST   1'b0
`define DJK_PULSE_HIGH  1'b1

`endif

// ### core/djk_pkg.sv
package djk_pkg;

  typedef enum logic [1:0]
  {
    DJK_IDLE    = 2'b00,
    DJK_SAMPLED = 2'b01
  } djk_phase_type;

  typedef struct packed
  {
    djk_phase_type phase;
    logic          clk_prev;
    logic          master;
    logic          slave;
  } djk_state_type;

endpackage

// ### core/djk_dual_flop.sv
// How it works
// R1 - Inputs reach master only during clock pulse
// R2 - Pulse start isolates slave, outputs hold
// R3 - Then load J and K into master
// R4 - Then ignore J and K inputs
// R5 - Finally copy master into slave outputs
// R6 - Hold, reset, set, toggle per J K
// R7 - New state shows only after pulse
// R8 - Low clear forces state zero
`timescale 1ns/10ps
`default_nettype none
`include "djk_defines.svh"

module djk_dual_flop
  import djk_pkg::*;
(
  input  wire logic [`DJK_NUM_FF-1:0] i_ff_clk,
  input  wire logic [`DJK_NUM_FF-1:0] i_j,
  input  wire logic [`DJK_NUM_FF-1:0] i_k,
  input  wire logic [`DJK_NUM_FF-1:0] i_clear_n,
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  output logic      [`DJK_NUM_FF-1:0] o_q,
  output logic      [`DJK_NUM_FF-1:0] o_q_n
);

  // Pulses are sampled on i_mclk, so each must span at least one rising mclk edge
  genvar g;
  generate
    for (g = 0; g < `DJK_NUM_FF; g++)
    begin : g_ff
      djk_stage u_stage
      (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_ff_clk    (i_ff_clk[g]),
        .i_set_req   (i_j[g]),
        .i_reset_req (i_k[g]),
        .i_clear_n   (i_clear_n[g]),
        .o_q         (o_q[g]),
        .o_q_n       (o_q_n[g])
      );

      // Flops are independent: only its own pulse end or clear moves one
      a_quiet_hold: assert property (@(posedge i_mclk) disable iff (i_rst) // [R7]
        !$fell(i_ff_clk[g]) && i_clear_n[g] |=> $stable(o_q[g]))
        else $error("Output moved without pulse end");
      a_outputs_paired: assert property (@(posedge i_mclk) disable iff (i_rst) // [R5]
        o_q_n[g] == !o_q[g])
        else $error("Outputs not complementary");
      a_clear_top: assert property (@(posedge i_mclk) disable iff (i_rst) // [R8]
        !i_clear_n[g] |=> !o_q[g])
        else $error("Clear did not reach output");
    end
  endgenerate

endmodule // djk_dual_flop

`default_nettype wire

// ### verification/djk_board_model.sv
`timescale 1ns/10ps
`default_nettype none

module djk_board_model
(
  input  wire logic       i_mclk,
  input  wire logic [1:0] i_fire,
  output var  logic [1:0] o_ff_clk = 2'h0
);
  // Falling edge launch keeps pulses clear of the sampling edge
  always @(negedge i_mclk)
  begin
    o_ff_clk <= i_fire;
  end
endmodule // djk_board_model

`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end

module testbench;
  logic       i_mclk    = 1'b0;
  logic       i_rst     = 1'b1;
  logic [1:0] fire      = 2'h0;
  logic [1:0] i_j       = 2'h0;
  logic [1:0] i_k       = 2'h0;
  logic [1:0] i_clear_n = 2'h3;
  logic [1:0] exp_q     = 2'h0;
  logic [1:0] ff_clk;
  logic [1:0] o_q;
  logic [1:0] o_q_n;
  int         fails     = 0;
  int         checks    = 0;

  always #25 i_mclk = ~i_mclk;

  djk_board_model djk_board_model_i (.i_mclk(i_mclk), .i_fire(fire), .o_ff_clk(ff_clk));
  djk_dual_flop djk_dual_flop_i (.i_ff_clk(ff_clk), .i_j(i_j), .i_k(i_k),
    .i_clear_n(i_clear_n), .i_mclk(i_mclk), .i_rst(i_rst), .o_q(o_q), .o_q_n(o_q_n));

  function automatic logic nxt(logic q, logic j, logic k);
    return j ? (k ? ~q : 1'b1) : (k ? 1'b0 : q);
  endfunction

  task automatic end_sim;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic pulse(int f, logic j, logic k);
    @(negedge i_mclk);
    i_j[f] = j;
    i_k[f] = k;
    @(posedge i_mclk);
    fire[f] <= 1'b1;
    @(posedge i_mclk);
    fire[f] <= 1'b0;
    @(negedge i_mclk);
    // Late J/K flip must not leak in
    i_j[f] = ~j;
    i_k[f] = ~k;
    `CHK(o_q, exp_q)
    exp_q[f] = nxt(exp_q[f], j, k);
    // Transfer lands at the first edge that sees the pulse low
    @(negedge i_mclk);
    `CHK(o_q, exp_q)
    `CHK(o_q_n, ~exp_q)
    @(negedge i_mclk);
    `CHK(o_q, exp_q)
  endtask

  initial
  begin
    void'($urandom(43));
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    `CHK(o_q, 2'h0)
    for (int c = 0; c < 8; c++)
      pulse(c / 4, 1'(c >> 1), 1'(c));
    for (int n = 0; n < 60; n++)
    begin
      pulse(int'($urandom % 2), 1'($urandom), 1'($urandom));
      if (n % 7 == 3)
      begin
        @(negedge i_mclk);
        i_clear_n[n % 2] = 1'b0;
        @(negedge i_mclk);
        exp_q[n % 2] = 1'b0;
        `CHK(o_q, exp_q)
        i_clear_n[n % 2] = 1'b1;
      end
    end
    end_sim();
  end
endmodule // testbench

`default_nettype wire
